// ---- hdl/sbc_pkg.sv ----
// constants and types shared by the serial lane bit error checker
package sbc_pkg;
	localparam int unsigned DATA_W = 40;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned HIST_W = 31;
	localparam int unsigned MAX_LANES = 8;
	localparam int unsigned LANE_W = 3;
	localparam int unsigned IDX_W = 10;
	localparam int unsigned POP_W = 6;
	// ****************************************************************
	// register indices, byte address is four times the index
	// ****************************************************************
	localparam logic [9:0] IDX_CHK_EN = 10'h315;
	localparam logic [9:0] IDX_CHK_CTRL = 10'h316;
	localparam logic [9:0] IDX_THR_LO = 10'h317;
	localparam logic [9:0] IDX_THR_MID = 10'h318;
	localparam logic [9:0] IDX_THR_HI = 10'h319;
	localparam logic [9:0] IDX_CNT_LO = 10'h31a;
	localparam logic [9:0] IDX_CNT_MID = 10'h31b;
	localparam logic [9:0] IDX_CNT_HI = 10'h31c;
	localparam logic [9:0] IDX_PASS = 10'h31d;
	localparam logic [9:0] IDX_CAP_CTRL = 10'h31e;
	localparam logic [9:0] IDX_CAP_B0 = 10'h31f;
	localparam logic [9:0] IDX_CAP_B1 = 10'h320;
	localparam logic [9:0] IDX_CAP_B2 = 10'h321;
	localparam logic [9:0] IDX_CAP_B3 = 10'h322;
	localparam logic [9:0] IDX_CAP_B4 = 10'h323;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h324;
	localparam logic [9:0] IDX_IRQ_EN = 10'h325;
	localparam logic [9:0] IDX_IRQ_CLR = 10'h326;
	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int unsigned CTRL_RST_BIT = 0;
	localparam int unsigned CTRL_RUN_BIT = 1;
	localparam int unsigned CTRL_PAT_LSB = 2;
	localparam int unsigned CTRL_LANE_LSB = 4;
	localparam int unsigned CAP_REQ_BIT = 0;
	localparam int unsigned CAP_MODE_BIT = 1;
	localparam int unsigned IRQ_FAIL_BIT = 0;
	localparam int unsigned IRQ_CAP_BIT = 1;
	localparam logic [7:0] PASS_RST = 8'hff;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [23:0] CNT_RST = 24'h00_0000;
	localparam logic [39:0] SNAP_RST = 40'h00_0000_0000;
	localparam logic [30:0] HIST_RST = 31'h0000_0000;
	localparam int unsigned TAP7_A = 7;
	localparam int unsigned TAP7_B = 6;
	localparam int unsigned TAP15_A = 15;
	localparam int unsigned TAP15_B = 14;
	localparam int unsigned TAP31_A = 31;
	localparam int unsigned TAP31_B = 28;
	typedef enum logic [1:0] {
		PAT_PRBS7 = 2'h0,
		PAT_PRBS15 = 2'h1,
		PAT_PRBS31 = 2'h2,
		PAT_NONE = 2'h3
	} sbc_pat_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN = 3'h2,
		ST_FAIL = 3'h4
	} sbc_state_t;
endpackage

// ---- hdl/sbc_ifs.sv ----
// interfaces between the checker top, its lane checkers and its bus port
`timescale 1ns/1ps
`default_nettype none
interface sbc_lane_if;
	logic [sbc_pkg::DATA_W-1:0] rx_data;
	logic rx_valid;
	logic run;
	logic clear;
	sbc_pkg::sbc_pat_t pattern;
	logic [sbc_pkg::CNT_W-1:0] threshold;
	logic [sbc_pkg::CNT_W-1:0] err_cnt;
	logic pass;
	logic err_evt;
	logic fail_evt;
	modport chk (input rx_data, rx_valid, run, clear, pattern, threshold,
		output err_cnt, pass, err_evt, fail_evt);
	modport ctl (output rx_data, rx_valid, run, clear, pattern, threshold,
		input err_cnt, pass, err_evt, fail_evt);
endinterface
interface sbc_reg_if;
	logic wr;
	logic [sbc_pkg::IDX_W-1:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport port (output wr, idx, wdata, input rdata);
	modport regs (input wr, idx, wdata, output rdata);
endinterface
`default_nettype wire

// ---- hdl/sbc_lane_chk.sv ----
// one lane: self-synchronising pattern check, error count, pass state
`timescale 1ns/1ps
`default_nettype none
module sbc_lane_chk (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	sbc_lane_if.chk lane
);
	typedef struct packed {
		sbc_pkg::sbc_state_t st;
		logic primed;
		logic [sbc_pkg::HIST_W-1:0] hist;
		logic [sbc_pkg::CNT_W-1:0] cnt;
	} sbc_lane_st_t;
	sbc_lane_st_t s_q;
	sbc_lane_st_t s_d;
	logic [sbc_pkg::HIST_W+sbc_pkg::DATA_W-1:0] stream;
	logic [sbc_pkg::DATA_W-1:0] miss;
	logic [sbc_pkg::POP_W-1:0] nerr;
	logic [sbc_pkg::CNT_W:0] sum;
	function automatic logic [sbc_pkg::POP_W-1:0] sbc_ones(input logic [sbc_pkg::DATA_W-1:0] v);
		logic [sbc_pkg::POP_W-1:0] n;
		n = '0;
		for (int i = 0; i < sbc_pkg::DATA_W; i++) begin
			n = n + sbc_pkg::POP_W'(v[i]);
		end
		return n;
	endfunction
	// bit 0 is the earliest bit; each bit is predicted from received history,
	// so one line error shows as up to three mismatches
	always_comb begin
		stream = {lane.rx_data, s_q.hist};
		for (int i = 0; i < sbc_pkg::DATA_W; i++) begin
			case (lane.pattern)
				sbc_pkg::PAT_PRBS7: miss[i] = stream[sbc_pkg::HIST_W+i] ^ stream[sbc_pkg::HIST_W+i-sbc_pkg::TAP7_A] ^ stream[sbc_pkg::HIST_W+i-sbc_pkg::TAP7_B];
				sbc_pkg::PAT_PRBS15: miss[i] = stream[sbc_pkg::HIST_W+i] ^ stream[sbc_pkg::HIST_W+i-sbc_pkg::TAP15_A] ^ stream[sbc_pkg::HIST_W+i-sbc_pkg::TAP15_B];
				sbc_pkg::PAT_PRBS31: miss[i] = stream[sbc_pkg::HIST_W+i] ^ stream[sbc_pkg::HIST_W+i-sbc_pkg::TAP31_A] ^ stream[sbc_pkg::HIST_W+i-sbc_pkg::TAP31_B];
				default: miss[i] = 1'b0;
			endcase
		end
		nerr = sbc_ones(miss);
		sum = {1'b0, s_q.cnt} + (sbc_pkg::CNT_W+1)'(nerr);
		s_d = s_q;
		if (lane.clear) begin
			s_d = '{sbc_pkg::ST_IDLE, 1'b0, sbc_pkg::HIST_RST, sbc_pkg::CNT_RST};
		end else if (!lane.run) begin
			s_d.primed = 1'b0;
			if (s_q.st == sbc_pkg::ST_RUN) begin
				s_d.st = sbc_pkg::ST_IDLE;
			end
		end else if (lane.rx_valid) begin
			s_d.hist = lane.rx_data[sbc_pkg::DATA_W-1 -: sbc_pkg::HIST_W];
			s_d.primed = 1'b1;
			case (s_q.st)
				sbc_pkg::ST_IDLE: begin
					s_d.st = sbc_pkg::ST_RUN;
				end
				sbc_pkg::ST_RUN, sbc_pkg::ST_FAIL: begin
					if (s_q.primed) begin
						s_d.cnt = sum[sbc_pkg::CNT_W] ? '1 : sum[sbc_pkg::CNT_W-1:0];
					end
					if (s_d.cnt > lane.threshold) begin
						s_d.st = sbc_pkg::ST_FAIL;
					end
				end
				default: s_d.st = sbc_pkg::ST_IDLE;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_q <= '{sbc_pkg::ST_IDLE, 1'b0, sbc_pkg::HIST_RST, sbc_pkg::CNT_RST};
		end else if (ce) begin
			s_q <= s_d;
		end
	end
	assign lane.err_cnt = s_q.cnt;
	assign lane.pass = (s_q.st != sbc_pkg::ST_FAIL);
	assign lane.err_evt = ce && !lane.clear && lane.run && lane.rx_valid && s_q.primed && (nerr != '0);
	assign lane.fail_evt = ce && (s_d.st == sbc_pkg::ST_FAIL) && (s_q.st != sbc_pkg::ST_FAIL);
	clear_cnt_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		ce && lane.clear |=> s_q.cnt == '0 && lane.pass) else $error("test reset left count or fail");
	halt_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!lane.run && !lane.clear |=> $stable(s_q.cnt)) else $error("count moved while halted");
	fail_sticky_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!lane.pass && !lane.clear |=> !lane.pass) else $error("fail flag recovered without reset");
	fail_cause_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(lane.pass) |-> s_q.cnt > $past(lane.threshold)) else $error("fail below threshold");
endmodule
`default_nettype wire

// ---- hdl/sbc_wb_port.sv ----
// classic wishbone slave front end: one wait state, byte data in lane 0
`timescale 1ns/1ps
`default_nettype none
module sbc_wb_port (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	sbc_reg_if.port rif
);
	typedef struct packed {
		logic ack;
		logic [7:0] dat;
	} sbc_port_st_t;
	sbc_port_st_t s_q;
	sbc_port_st_t s_d;
	logic req;
	assign req = wb_cyc_i && wb_stb_i;
	always_comb begin
		s_d = s_q;
		s_d.ack = req && !s_q.ack;
		if (req && !s_q.ack && !wb_we_i) begin
			s_d.dat = rif.rdata;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_q <= '{1'b0, sbc_pkg::BYTE_RST};
		end else if (ce) begin
			s_q <= s_d;
		end
	end
	// writes land on the edge at which the master sees ack
	assign rif.wr = ce && req && wb_we_i && s_q.ack && wb_sel_i[0];
	assign rif.idx = wb_adr_i[11:2];
	assign rif.wdata = wb_dat_i[7:0];
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = {24'h00_0000, s_q.dat};
	ack_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// ---- hdl/sbc_prbs_checker.sv ----
// serial lane bit error rate checker with snapshot capture, wishbone registers
//
// Behaviour
// - writing one to test reset clears the state machines and lane counters
// - the 24-bit threshold is three byte registers, low byte first, reset zero
// - selected lane error count reads as three bytes, low byte first
// - pass status holds one flag per lane, all ones after reset
// - capture mode zero uses the software request, one captures on bit error
// - a zero to one request transition captures the selected lane word once
// - the 40-bit snapshot reads as five bytes, byte zero lowest, reset zero
// - checking stays stopped until the test enable field is set
// - pattern select 00/01/10 picks PRBS7/15/31, 11 checks nothing
// - three-bit lane select picks lanes zero to seven directly
// - test start set runs checking and counting, cleared halts it
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sbc_prbs_checker #(
	parameter int unsigned LANES = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [LANES*sbc_pkg::DATA_W-1:0] lane_rx_data,
	input wire logic [LANES-1:0] lane_rx_valid,
	output logic irq
);
	// ****************************************************************
	// parameter checks
	// ****************************************************************
	if (LANES < 1 || LANES > sbc_pkg::MAX_LANES) begin : g_bad_lanes
		$error("LANES must be 1 to 8");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] chk_en;
		logic [sbc_pkg::LANE_W-1:0] lane_sel;
		sbc_pkg::sbc_pat_t pat;
		logic run;
		logic chk_rst;
		logic [sbc_pkg::CNT_W-1:0] thr;
		logic cap_mode;
		logic cap_req;
		logic [sbc_pkg::DATA_W-1:0] snap;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
	} sbc_top_st_t;
	sbc_top_st_t s_q;
	sbc_top_st_t s_d;
	localparam sbc_top_st_t TOP_RST = '{
		sbc_pkg::BYTE_RST,
		3'h0,
		sbc_pkg::PAT_PRBS7,
		1'b0,
		1'b0,
		sbc_pkg::CNT_RST,
		1'b0,
		1'b0,
		sbc_pkg::SNAP_RST,
		2'h0,
		2'h0
	};

	sbc_reg_if rif();
	wire logic [sbc_pkg::MAX_LANES-1:0][sbc_pkg::CNT_W-1:0] cnt_arr;
	wire logic [sbc_pkg::MAX_LANES-1:0][sbc_pkg::DATA_W-1:0] word_arr;
	wire logic [sbc_pkg::MAX_LANES-1:0] pass_vec;
	wire logic [sbc_pkg::MAX_LANES-1:0] err_vec;
	wire logic [sbc_pkg::MAX_LANES-1:0] fail_vec;
	logic lanes_run;
	logic [sbc_pkg::CNT_W-1:0] sel_cnt;
	logic [sbc_pkg::DATA_W-1:0] sel_word;
	logic sel_err;
	logic cap_sw;
	logic cap_err;
	logic [1:0] irq_set;
	logic [7:0] rd_byte;

	// gating the checkers by enable rather than by clock keeps one clock tree
	assign lanes_run = (s_q.chk_en != 8'h00) && s_q.run;
	assign sel_cnt = cnt_arr[s_q.lane_sel];
	assign sel_word = word_arr[s_q.lane_sel];
	assign sel_err = err_vec[s_q.lane_sel];

	// ****************************************************************
	// lane checkers
	// ****************************************************************
	for (genvar g = 0; g < sbc_pkg::MAX_LANES; g++) begin : g_lane
		if (g < LANES) begin : g_on
			sbc_lane_if lif();
			assign lif.rx_data = lane_rx_data[g*sbc_pkg::DATA_W +: sbc_pkg::DATA_W];
			assign lif.rx_valid = lane_rx_valid[g];
			assign lif.run = lanes_run;
			assign lif.clear = s_q.chk_rst;
			assign lif.pattern = s_q.pat;
			assign lif.threshold = s_q.thr;
			sbc_lane_chk u_chk (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.ce(ce),
				.lane(lif)
			);
			assign cnt_arr[g] = lif.err_cnt;
			assign word_arr[g] = lif.rx_data;
			assign pass_vec[g] = lif.pass;
			assign err_vec[g] = lif.err_evt;
			assign fail_vec[g] = lif.fail_evt;
		end else begin : g_off
			// absent lanes count nothing and report pass
			assign cnt_arr[g] = sbc_pkg::CNT_RST;
			assign word_arr[g] = sbc_pkg::SNAP_RST;
			assign pass_vec[g] = 1'b1;
			assign err_vec[g] = 1'b0;
			assign fail_vec[g] = 1'b0;
		end
	end

	// ****************************************************************
	// bus port
	// ****************************************************************
	sbc_wb_port u_port (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(ce),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.rif(rif)
	);

	// ****************************************************************
	// register writes, capture and interrupt status
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		cap_sw = 1'b0;
		if (rif.wr) begin
			case (rif.idx)
				sbc_pkg::IDX_CHK_EN: s_d.chk_en = rif.wdata;
				sbc_pkg::IDX_CHK_CTRL: begin
					s_d.lane_sel = rif.wdata[sbc_pkg::CTRL_LANE_LSB +: sbc_pkg::LANE_W];
					s_d.pat = sbc_pkg::sbc_pat_t'(rif.wdata[sbc_pkg::CTRL_PAT_LSB +: 2]);
					s_d.run = rif.wdata[sbc_pkg::CTRL_RUN_BIT];
					s_d.chk_rst = rif.wdata[sbc_pkg::CTRL_RST_BIT];
				end
				sbc_pkg::IDX_THR_LO: s_d.thr[7:0] = rif.wdata;
				sbc_pkg::IDX_THR_MID: s_d.thr[15:8] = rif.wdata;
				sbc_pkg::IDX_THR_HI: s_d.thr[23:16] = rif.wdata;
				sbc_pkg::IDX_CAP_CTRL: begin
					s_d.cap_mode = rif.wdata[sbc_pkg::CAP_MODE_BIT];
					s_d.cap_req = rif.wdata[sbc_pkg::CAP_REQ_BIT];
					// only the 0 to 1 edge captures, in software mode
					cap_sw = rif.wdata[sbc_pkg::CAP_REQ_BIT] && !s_q.cap_req
						&& !rif.wdata[sbc_pkg::CAP_MODE_BIT];
				end
				sbc_pkg::IDX_IRQ_EN: s_d.irq_en = rif.wdata[1:0];
				sbc_pkg::IDX_IRQ_CLR: s_d.irq_stat = s_q.irq_stat & ~rif.wdata[1:0];
				default: ;
			endcase
		end
		// error mode keeps the latest word that held an error
		cap_err = s_q.cap_mode && sel_err;
		if (cap_sw || cap_err) begin
			s_d.snap = sel_word;
		end
		irq_set = '0;
		irq_set[sbc_pkg::IRQ_FAIL_BIT] = |fail_vec;
		irq_set[sbc_pkg::IRQ_CAP_BIT] = cap_sw || cap_err;
		// a new event wins over a clear in the same cycle
		s_d.irq_stat = s_d.irq_stat | irq_set;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_q <= TOP_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign irq = |(s_q.irq_stat & s_q.irq_en);

	// ****************************************************************
	// register reads
	// ****************************************************************
	always_comb begin
		case (rif.idx)
			sbc_pkg::IDX_CHK_EN: rd_byte = s_q.chk_en;
			sbc_pkg::IDX_CHK_CTRL: rd_byte = {1'b0, s_q.lane_sel, s_q.pat, s_q.run, s_q.chk_rst};
			sbc_pkg::IDX_THR_LO: rd_byte = s_q.thr[7:0];
			sbc_pkg::IDX_THR_MID: rd_byte = s_q.thr[15:8];
			sbc_pkg::IDX_THR_HI: rd_byte = s_q.thr[23:16];
			sbc_pkg::IDX_CNT_LO: rd_byte = sel_cnt[7:0];
			sbc_pkg::IDX_CNT_MID: rd_byte = sel_cnt[15:8];
			sbc_pkg::IDX_CNT_HI: rd_byte = sel_cnt[23:16];
			sbc_pkg::IDX_PASS: rd_byte = pass_vec;
			sbc_pkg::IDX_CAP_CTRL: rd_byte = {6'h00, s_q.cap_mode, s_q.cap_req};
			sbc_pkg::IDX_CAP_B0: rd_byte = s_q.snap[7:0];
			sbc_pkg::IDX_CAP_B1: rd_byte = s_q.snap[15:8];
			sbc_pkg::IDX_CAP_B2: rd_byte = s_q.snap[23:16];
			sbc_pkg::IDX_CAP_B3: rd_byte = s_q.snap[31:24];
			sbc_pkg::IDX_CAP_B4: rd_byte = s_q.snap[39:32];
			sbc_pkg::IDX_IRQ_STAT: rd_byte = {6'h00, s_q.irq_stat};
			sbc_pkg::IDX_IRQ_EN: rd_byte = {6'h00, s_q.irq_en};
			default: rd_byte = sbc_pkg::BYTE_RST;
		endcase
	end
	assign rif.rdata = rd_byte;

	// ****************************************************************
	// assertions
	// ****************************************************************
	thr_mid_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		rif.wr && rif.idx == sbc_pkg::IDX_THR_MID
		|=> s_q.thr[15:8] == $past(rif.wdata) && $stable(s_q.thr[7:0]))
		else $error("threshold middle byte not written");
	cnt_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce
		&& wb_adr_i[11:2] == sbc_pkg::IDX_CNT_HI
		|=> wb_ack_o && wb_dat_o[7:0] == $past(sel_cnt[23:16]))
		else $error("selected count high byte read wrong");
	pass_after_rst_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(resetn) |-> pass_vec == sbc_pkg::PASS_RST)
		else $error("pass flags not all set after reset");
	cap_sw_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		cap_sw |=> s_q.snap == $past(sel_word))
		else $error("software capture missed lane word");
	steady_req_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		rif.wr && rif.idx == sbc_pkg::IDX_CAP_CTRL && s_q.cap_req && !s_q.cap_mode
		&& rif.wdata[sbc_pkg::CAP_REQ_BIT]
		|=> $stable(s_q.snap))
		else $error("steady request captured again");
	cap_err_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		ce && s_q.cap_mode && sel_err |=> s_q.snap == $past(sel_word))
		else $error("error capture missed lane word");
	no_err_cap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		ce && !s_q.cap_mode && !cap_sw |=> $stable(s_q.snap))
		else $error("capture without trigger in software mode");
	snap_b4_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce
		&& wb_adr_i[11:2] == sbc_pkg::IDX_CAP_B4
		|=> wb_dat_o[7:0] == $past(s_q.snap[39:32]))
		else $error("snapshot byte four read wrong");
	enable_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_q.chk_en == 8'h00 && !s_q.chk_rst |=> $stable(cnt_arr))
		else $error("counts moved while test disabled");
	rst_clears_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		ce && s_q.chk_rst |=> cnt_arr == '0 && pass_vec == sbc_pkg::PASS_RST)
		else $error("test reset did not clear lanes");
	stat_sticky_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		ce && |irq_set |=> (s_q.irq_stat & $past(irq_set)) == $past(irq_set))
		else $error("event lost against clear");
	// ****************************************************************
	// control fields and status reads
	// ****************************************************************
	thr_low_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		rif.wr && rif.idx == sbc_pkg::IDX_THR_LO
		|=> s_q.thr[7:0] == $past(rif.wdata) && $stable(s_q.thr[23:8]))
		else $error("threshold low byte not written");
	pass_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce
		&& wb_adr_i[11:2] == sbc_pkg::IDX_PASS
		|=> wb_dat_o[7:0] == $past(pass_vec))
		else $error("pass flags read wrong");
	mode_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		rif.wr && rif.idx == sbc_pkg::IDX_CAP_CTRL
		|=> s_q.cap_mode == $past(rif.wdata[sbc_pkg::CAP_MODE_BIT]))
		else $error("capture mode not written");
	// code 11 must leave every count alone, whatever the line carries
	pat_none_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_q.pat == sbc_pkg::PAT_NONE && !s_q.chk_rst |=> $stable(cnt_arr))
		else $error("unused pattern code counted errors");
	lane_sel_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		rif.wr && rif.idx == sbc_pkg::IDX_CHK_CTRL
		|=> s_q.lane_sel == $past(rif.wdata[sbc_pkg::CTRL_LANE_LSB +: sbc_pkg::LANE_W]))
		else $error("lane select not written");
	run_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s_q.run && !s_q.chk_rst |=> $stable(cnt_arr))
		else $error("counts moved while test stopped");
	irq_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		rif.wr && rif.idx == sbc_pkg::IDX_IRQ_CLR && irq_set == 2'h0
		|=> (s_q.irq_stat & $past(rif.wdata[1:0])) == 2'h0)
		else $error("interrupt status not cleared");
	// ****************************************************************
	// covers
	// ****************************************************************
	lane_fail_c: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(pass_vec[0]));
	cap_sw_c: cover property (@(posedge ref_clk) disable iff (!resetn) cap_sw);
	cap_err_c: cover property (@(posedge ref_clk) disable iff (!resetn) ce && cap_err);
	irq_c: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(irq));
	pat_none_c: cover property (@(posedge ref_clk) disable iff (!resetn)
		lanes_run && s_q.pat == sbc_pkg::PAT_NONE);
endmodule
`default_nettype wire

// ---- tb/sbc_prbs_tx.sv ----
// far side model: pattern transmitter feeding all eight lanes
`timescale 1ns/1ps
`default_nettype none
module sbc_prbs_tx (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [1:0] pattern,
	input wire logic hold,
	input wire logic inject,
	input wire logic [2:0] inj_lane,
	output logic [319:0] lane_rx_data,
	output logic [7:0] lane_rx_valid,
	output logic [39:0] word_q,
	output logic [39:0] err_word_q
);
	logic [30:0] hist_q;
	logic valid_q;
	// valid drops while held so a repeated word is never checked
	always_comb begin
		for (int g = 0; g < 8; g++) begin
			lane_rx_data[g*40 +: 40] = word_q ^ ((inject && inj_lane == 3'(g)) ? 40'h20 : 40'h0);
		end
		lane_rx_valid = {8{valid_q & ~hold}};
	end
	always_ff @(posedge ref_clk) begin
		logic [30:0] h;
		logic [39:0] w;
		logic nb;
		h = hist_q;
		for (int i = 0; i < 40; i++) begin
			case (pattern)
				2'h1: nb = h[14] ^ h[13];
				2'h2: nb = h[30] ^ h[27];
				default: nb = h[6] ^ h[5];
			endcase
			w[i] = nb;
			h = {h[29:0], nb};
		end
		if (!resetn) begin
			hist_q <= 31'h7fff_ffff;
			word_q <= 40'h0;
			valid_q <= 1'b0;
		end else if (!hold) begin
			hist_q <= h;
			word_q <= w;
			valid_q <= 1'b1;
		end
		if (inject) begin
			err_word_q <= word_q ^ 40'h20;
		end
	end
endmodule
`default_nettype wire

// ---- tb/sbc_prbs_checker_bench.sv ----
// self-checking bench for the lane bit error checker
`timescale 1ns/1ps
`default_nettype none
module sbc_prbs_checker_bench;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [11:0] wb_adr = 12'h000;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, irq;
	logic hold = 1'b0;
	logic inject = 1'b0;
	logic [1:0] pat = 2'h0;
	logic [2:0] lane = 3'h0;
	logic [319:0] rx_data;
	logic [7:0] rx_valid;
	logic [39:0] word, err_word, v, a;
	int bad_count = 0;
	int checks = 0;
	always #5 ref_clk = ~ref_clk;
	sbc_prbs_checker #(.LANES(8)) uut (.ref_clk(ref_clk), .resetn(resetn), .ce(1'b1),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'h1), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.lane_rx_data(rx_data), .lane_rx_valid(rx_valid), .irq(irq));
	sbc_prbs_tx tx (.ref_clk(ref_clk), .resetn(resetn), .pattern(pat), .hold(hold),
		.inject(inject), .inj_lane(lane), .lane_rx_data(rx_data), .lane_rx_valid(rx_valid),
		.word_q(word), .err_word_q(err_word));
	// ****************************************************************
	// report, compare and bus tasks
	// ****************************************************************
	task automatic end_sim;
		$display("mismatches %0d, checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic [9:0] idx, input logic we, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_dat <= {24'h00_0000, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) begin
			bad_count++;
			end_sim();
		end
		q = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [7:0] q;
		xfer(idx, 1'b1, d, q);
	endtask
	// multi-byte values come back low byte first
	task automatic rd(input logic [9:0] idx, input int n, output logic [39:0] r);
		logic [7:0] q;
		r = 40'h0;
		for (int i = 0; i < n; i++) begin
			xfer(idx + 10'(i), 1'b0, 8'h00, q);
			r[i*8 +: 8] = q;
		end
	endtask
	task automatic hit(input logic [2:0] l);
		lane <= l;
		inject <= 1'b1;
		@(posedge ref_clk);
		inject <= 1'b0;
		@(posedge ref_clk);
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(sbc_pkg::IDX_PASS, 1, v);
		chk(v, 8'hff);
		rd(sbc_pkg::IDX_THR_LO, 3, v);
		chk(v, 24'h00_0000);
		rd(sbc_pkg::IDX_CNT_LO, 3, v);
		chk(v, 24'h00_0000);
		rd(sbc_pkg::IDX_CAP_B0, 5, v);
		chk(v, 40'h0);
		wr(10'h000, 8'h5a);
		rd(10'h000, 1, v);
		chk(v, 8'h00);
		wr(sbc_pkg::IDX_THR_LO, 8'h02);
		wr(sbc_pkg::IDX_THR_MID, 8'h5a);
		wr(sbc_pkg::IDX_THR_HI, 8'ha5);
		rd(sbc_pkg::IDX_THR_LO, 3, v);
		chk(v, 24'ha5_5a02);
		wr(sbc_pkg::IDX_THR_MID, 8'h00);
		wr(sbc_pkg::IDX_THR_HI, 8'h00);
		// enable still zero: an error must go uncounted
		wr(sbc_pkg::IDX_CHK_CTRL, 8'h32);
		repeat (4) @(posedge ref_clk);
		hit(3'h3);
		rd(sbc_pkg::IDX_CNT_LO, 3, v);
		chk(v, 40'h0);
		wr(sbc_pkg::IDX_CHK_EN, 8'h01);
		for (int p = 0; p < 4; p++) begin
			pat <= 2'(p);
			wr(sbc_pkg::IDX_CHK_CTRL, 8'h01);
			wr(sbc_pkg::IDX_CHK_CTRL, {1'b0, 3'(2*p+1), 2'(p), 2'b10});
			rd(sbc_pkg::IDX_PASS, 1, v);
			chk(v, 8'hff);
			rd(sbc_pkg::IDX_CNT_LO, 3, v);
			chk(v, 40'h0);
			repeat (3) @(posedge ref_clk);
			hit(3'(2*p+1));
			rd(sbc_pkg::IDX_CNT_LO, 3, v);
			chk(v, (p == 3) ? 40'h0 : 40'h3);
			rd(sbc_pkg::IDX_PASS, 1, v);
			chk(v, (p == 3) ? 8'hff : 8'hff ^ (8'h01 << (2*p+1)));
			wr(sbc_pkg::IDX_CHK_CTRL, {1'b0, 3'(2*p), 2'(p), 2'b10});
			rd(sbc_pkg::IDX_CNT_LO, 3, v);
			chk(v, 40'h0);
			if (p == 0) begin
				chk(irq, 1'b0);
				wr(sbc_pkg::IDX_IRQ_EN, 8'h01);
				chk(irq, 1'b1);
				wr(sbc_pkg::IDX_IRQ_CLR, 8'h01);
				chk(irq, 1'b0);
				wr(sbc_pkg::IDX_IRQ_EN, 8'h00);
			end
		end
		pat <= 2'h0;
		wr(sbc_pkg::IDX_CHK_CTRL, 8'h01);
		wr(sbc_pkg::IDX_CHK_CTRL, 8'h02);
		repeat (3) @(posedge ref_clk);
		wr(sbc_pkg::IDX_CHK_CTRL, 8'h00);
		hit(3'h0);
		rd(sbc_pkg::IDX_CNT_LO, 3, v);
		chk(v, 40'h0);
		wr(sbc_pkg::IDX_CHK_CTRL, 8'h22);
		hold <= 1'b1;
		repeat (2) @(posedge ref_clk);
		a = word;
		wr(sbc_pkg::IDX_CAP_CTRL, 8'h01);
		rd(sbc_pkg::IDX_CAP_B0, 5, v);
		chk(v, a);
		hold <= 1'b0;
		repeat (3) @(posedge ref_clk);
		hold <= 1'b1;
		@(posedge ref_clk);
		wr(sbc_pkg::IDX_CAP_CTRL, 8'h01);
		rd(sbc_pkg::IDX_CAP_B0, 5, v);
		chk(v, a);
		wr(sbc_pkg::IDX_CAP_CTRL, 8'h00);
		wr(sbc_pkg::IDX_CAP_CTRL, 8'h01);
		rd(sbc_pkg::IDX_CAP_B0, 5, v);
		chk(v, word);
		hold <= 1'b0;
		wr(sbc_pkg::IDX_CAP_CTRL, 8'h02);
		repeat (3) @(posedge ref_clk);
		hit(3'h2);
		rd(sbc_pkg::IDX_CAP_B0, 5, v);
		chk(v, err_word);
		end_sim();
	end
endmodule
`default_nettype wire
